// ==== sbb_byte_access.sv ====
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RULE1] An 8-bit data byte register supplies write data and receives read data.
// [RULE2] An 8-bit index register is sent as the byte address inside the target.
// [RULE3] The upper seven bits of the target register hold the target address.
// [RULE4] Target register bit 0 chooses the access: 0 writes a byte, 1 reads one.
// [RULE5] The stored direction bit goes out with the target address on the bus.
// [RULE6] Software loads data and index, then the target register with bit 0 clear.
// [RULE7] Software loads the index, then the target register with bit 0 set.
// [RULE8] Software polls busy after a read; data byte is valid once busy clears.
// [RULE9] Writing the target register launches the access and sets busy until done.
// [RULE10] A missing acknowledge sets a sticky error flag, cleared by writing one.
// [RULE11] Short protocol select uses send and receive byte, leaving out the index.
// [RULE12] Serial clock runs near 100 kHz; a test bit makes it faster.
// [RULE13] Frame: start, address, index, data; reads repeat start and end with NACK; stop.
module sbb_byte_access
    import sbb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         link_clk,
    input  wire sbb_cfg_req_s cfg_req,
    output var  logic [7:0]   cfg_rdata,
    input  wire logic         scl_i,
    output var  logic         scl_o,
    output var  logic         scl_oe_n,
    input  wire logic         sda_i,
    output var  logic         sda_o,
    output var  logic         sda_oe_n
);
    localparam sbb_host_s HOST_RST = '{
        data:      SBB_RST_DATA,
        index:     SBB_RST_INDEX,
        target:    SBB_RST_TARGET,
        short_sel: SBB_RST_CTRL[SBB_CTRL_SHORT_BIT],
        fast:      SBB_RST_CTRL[SBB_CTRL_TEST_BIT],
        err:       SBB_RST_CTRL[SBB_CTRL_ERR_BIT],
        busy:      SBB_RST_CTRL[SBB_CTRL_BUSY_BIT],
        default:   '0
    };

    sbb_host_s  h_ff;
    sbb_host_s  nxt_h;
    sbb_link_s  l_ff;
    sbb_link_s  nxt_l;
    logic       link_rst_n;
    logic       done_sync;
    logic [3:0] link_in;
    logic       go;
    logic       fast;
    logic       scl_in;
    logic       sda_in;
    logic [7:0] qtr;
    logic       tick;
    logic       stretch;
    logic       rx_step;
    logic [7:0] ctrl_rb;

    // The link domain leaves reset only on its own clock edge.
    sbb_sync #(.W(1)) u_link_rst (
        .clk   (link_clk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (link_rst_n)
    );

    // Launch toggle, test level and both bus lines enter the link domain here.
    sbb_sync #(.W(4)) u_link_in (
        .clk   (link_clk),
        .rst_n (rst_n),
        .d     ({h_ff.launch_tgl, h_ff.fast, scl_i, sda_i}),
        .q     (link_in)
    );

    sbb_sync #(.W(1)) u_done (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (l_ff.done_tgl),
        .q     (done_sync)
    );

    assign go     = link_in[3];
    assign fast   = link_in[2];
    assign scl_in = link_in[1];
    assign sda_in = link_in[0];

    // ---------------- Register side, controller clock ----------------
    always_comb begin
        nxt_h   = h_ff;
        ctrl_rb = '0;
        ctrl_rb[SBB_CTRL_SHORT_BIT] = h_ff.short_sel;
        ctrl_rb[SBB_CTRL_BUSY_BIT]  = h_ff.busy;
        ctrl_rb[SBB_CTRL_TEST_BIT]  = h_ff.fast;
        ctrl_rb[SBB_CTRL_ERR_BIT]   = h_ff.err;

        // The link reads data, index and target without its own copy, so they are frozen while busy.
        if (cfg_req.wr) begin
            unique case (cfg_req.addr)
                SBB_OFS_DATA: if (!h_ff.busy) nxt_h.data = cfg_req.wdata; // RULE1
                SBB_OFS_INDEX: if (!h_ff.busy) nxt_h.index = cfg_req.wdata; // RULE2
                SBB_OFS_TARGET: begin
                    if (!h_ff.busy) begin
                        nxt_h.target     = cfg_req.wdata; // RULE3 RULE4
                        nxt_h.busy       = 1'b1; // RULE9
                        nxt_h.launch_tgl = ~h_ff.launch_tgl; // RULE9
                    end
                end
                SBB_OFS_CTRL: begin
                    nxt_h.fast = cfg_req.wdata[SBB_CTRL_TEST_BIT]; // RULE12
                    if (!h_ff.busy) nxt_h.short_sel = cfg_req.wdata[SBB_CTRL_SHORT_BIT]; // RULE11
                    if (cfg_req.wdata[SBB_CTRL_ERR_BIT]) nxt_h.err = 1'b0; // RULE10
                end
                default: ;
            endcase
        end

        // Completion is applied after the writes so a new error beats a clear in the same cycle.
        if (done_sync != h_ff.done_seen) begin
            nxt_h.done_seen = done_sync;
            nxt_h.busy      = 1'b0; // RULE9
            if (l_ff.err) begin
                nxt_h.err = 1'b1; // RULE10
            end else if (h_ff.target[SBB_TGT_DIR_BIT]) begin
                nxt_h.data = l_ff.rx; // RULE8 RULE1
            end
        end

        if (cfg_req.rd) begin
            unique case (cfg_req.addr)
                SBB_OFS_DATA:   nxt_h.rdata = h_ff.data;
                SBB_OFS_INDEX:  nxt_h.rdata = h_ff.index;
                SBB_OFS_TARGET: nxt_h.rdata = h_ff.target;
                SBB_OFS_CTRL:   nxt_h.rdata = ctrl_rb;
                default:        nxt_h.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            h_ff <= HOST_RST;
        end else begin
            h_ff <= nxt_h;
        end
    end

    assign cfg_rdata = h_ff.rdata;

    // ---------------- Serial engine, link clock ----------------
    function automatic logic [7:0] step_byte(input sbb_step_e s, input logic [7:0] tgt,
                                             input logic [7:0] idx, input logic [7:0] dat,
                                             input logic rd);
        logic [7:0] b;
        b = 8'h00;
        unique case (s)
            SBB_SQ_ADDR_W: b = {tgt[7:1], 1'b0};
            SBB_SQ_ADDR_R: b = {tgt[7:1], rd}; // RULE5
            SBB_SQ_INDEX:  b = idx; // RULE2 RULE7
            SBB_SQ_DATA_W: b = dat; // RULE1 RULE6
            default:       b = 8'h00;
        endcase
        return b;
    endfunction : step_byte

    always_comb begin
        nxt_l   = l_ff;
        qtr     = fast ? SBB_QTR_TEST : SBB_QTR_NORMAL; // RULE12
        // A target holding the clock low stretches the high phase.
        stretch = (l_ff.st != SBB_ST_IDLE) && !l_ff.scl_low && !scl_in;
        tick    = 1'b0;
        rx_step = (l_ff.step == SBB_SQ_DATA_R);

        if (l_ff.st != SBB_ST_IDLE && !stretch) begin
            if (l_ff.qcnt >= qtr - 8'h01) begin
                nxt_l.qcnt = 8'h00;
                tick       = 1'b1;
            end else begin
                nxt_l.qcnt = l_ff.qcnt + 8'h01;
            end
        end

        unique case (l_ff.st)
            SBB_ST_IDLE: begin
                if (go != l_ff.launch_seen) begin
                    nxt_l.launch_seen = go;
                    nxt_l.short_sel   = h_ff.short_sel;
                    nxt_l.rd          = h_ff.target[SBB_TGT_DIR_BIT]; // RULE4
                    nxt_l.err         = 1'b0;
                    nxt_l.step        = (h_ff.short_sel && h_ff.target[SBB_TGT_DIR_BIT]) ?
                                        SBB_SQ_ADDR_R : SBB_SQ_ADDR_W; // RULE11
                    nxt_l.st          = SBB_ST_START; // RULE13
                    nxt_l.phase       = 2'h0;
                    nxt_l.qcnt        = 8'h00;
                end
            end
            SBB_ST_START: begin
                if (tick) begin
                    nxt_l.phase = l_ff.phase + 2'h1;
                    if (l_ff.phase == 2'h3) begin
                        nxt_l.st     = SBB_ST_BIT;
                        nxt_l.bitcnt = 4'h0;
                        nxt_l.shreg  = step_byte(l_ff.step, h_ff.target, h_ff.index, h_ff.data, l_ff.rd);
                    end
                end
            end
            SBB_ST_BIT: begin
                if (tick) begin
                    nxt_l.phase = l_ff.phase + 2'h1;
                    if (l_ff.phase == 2'h1) begin
                        if (l_ff.bitcnt == 4'h8) begin
                            if (!rx_step && sda_in) nxt_l.err = 1'b1; // RULE10
                        end else if (rx_step) begin
                            nxt_l.rx = {l_ff.rx[6:0], sda_in}; // RULE1
                        end
                    end
                    if (l_ff.phase == 2'h3) begin
                        nxt_l.shreg = {l_ff.shreg[6:0], 1'b0};
                        if (l_ff.bitcnt != 4'h8) begin
                            nxt_l.bitcnt = l_ff.bitcnt + 4'h1;
                        end else begin
                            nxt_l.bitcnt = 4'h0;
                            if (nxt_l.err) begin
                                nxt_l.st = SBB_ST_STOP;
                            end else begin
                                unique case (l_ff.step)
                                    SBB_SQ_ADDR_W: nxt_l.step = l_ff.short_sel ? SBB_SQ_DATA_W :
                                                                SBB_SQ_INDEX; // RULE11 RULE13
                                    SBB_SQ_INDEX: begin
                                        if (l_ff.rd) begin
                                            nxt_l.st   = SBB_ST_START; // RULE13
                                            nxt_l.step = SBB_SQ_ADDR_R;
                                        end else begin
                                            nxt_l.step = SBB_SQ_DATA_W;
                                        end
                                    end
                                    SBB_SQ_ADDR_R: nxt_l.step = SBB_SQ_DATA_R;
                                    default:       nxt_l.st   = SBB_ST_STOP; // RULE13
                                endcase
                                nxt_l.shreg = step_byte(nxt_l.step, h_ff.target, h_ff.index, h_ff.data,
                                                        l_ff.rd);
                            end
                        end
                    end
                end
            end
            SBB_ST_STOP: begin
                if (tick) begin
                    nxt_l.phase = l_ff.phase + 2'h1;
                    if (l_ff.phase == 2'h3) begin
                        nxt_l.st       = SBB_ST_IDLE;
                        nxt_l.done_tgl = ~l_ff.done_tgl; // RULE8
                    end
                end
            end
        endcase

        // Line drive follows the next state and phase, so the pins come straight from flops.
        unique case (nxt_l.st)
            SBB_ST_IDLE: begin
                nxt_l.scl_low = 1'b0;
                nxt_l.sda_low = 1'b0;
            end
            SBB_ST_START: begin
                nxt_l.scl_low = (nxt_l.phase == 2'h0) || (nxt_l.phase == 2'h3);
                nxt_l.sda_low = nxt_l.phase[1]; // RULE13
            end
            SBB_ST_BIT: begin
                nxt_l.scl_low = (nxt_l.phase == 2'h0) || (nxt_l.phase == 2'h3);
                // The ack slot of the received byte is left released, which gives the final NACK.
                nxt_l.sda_low = (nxt_l.step != SBB_SQ_DATA_R) && (nxt_l.bitcnt != 4'h8) &&
                                !nxt_l.shreg[7]; // RULE5 RULE13
            end
            SBB_ST_STOP: begin
                nxt_l.scl_low = (nxt_l.phase == 2'h0);
                nxt_l.sda_low = (nxt_l.phase < 2'h2); // RULE13
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_ff <= '{st: SBB_ST_IDLE, step: SBB_SQ_ADDR_W, default: '0};
        end else begin
            l_ff <= nxt_l;
        end
    end

    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = ~l_ff.scl_low;
    assign sda_oe_n = ~l_ff.sda_low;

    // ---------------- Checks ----------------
    AST_DATA_WR: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        cfg_req.wr && cfg_req.addr == SBB_OFS_DATA && !h_ff.busy |=> h_ff.data == $past(cfg_req.wdata))
        else $error("Data byte register missed a write.");

    AST_INDEX_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        h_ff.busy |=> h_ff.index == $past(h_ff.index))
        else $error("Index changed during an access.");

    AST_TARGET_RB: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        cfg_req.rd && cfg_req.addr == SBB_OFS_TARGET |=> cfg_rdata == $past(h_ff.target))
        else $error("Target register readback wrong.");

    AST_LAUNCH: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        cfg_req.wr && cfg_req.addr == SBB_OFS_TARGET && !h_ff.busy
        |=> h_ff.busy && h_ff.launch_tgl != $past(h_ff.launch_tgl) && h_ff.target == $past(cfg_req.wdata))
        else $error("Target write did not launch an access.");

    AST_ERR_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        h_ff.err && !(cfg_req.wr && cfg_req.addr == SBB_OFS_CTRL && cfg_req.wdata[SBB_CTRL_ERR_BIT])
        |=> h_ff.err)
        else $error("Error flag dropped without a clear.");

    AST_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        $fell(h_ff.busy) && h_ff.target[SBB_TGT_DIR_BIT] && !h_ff.err |-> h_ff.data == l_ff.rx)
        else $error("Read data not valid when busy cleared.");

    AST_DIR_BIT: assert property (@(posedge link_clk) disable iff (!link_rst_n) // RULE5
        l_ff.st == SBB_ST_BIT && l_ff.bitcnt == 4'h7 && l_ff.phase == 2'h1 &&
        (l_ff.step == SBB_SQ_ADDR_W || l_ff.step == SBB_SQ_ADDR_R)
        |-> l_ff.sda_low == (l_ff.step == SBB_SQ_ADDR_W))
        else $error("Direction bit on the bus is wrong.");

    AST_NO_INDEX: assert property (@(posedge link_clk) disable iff (!link_rst_n) // RULE11
        l_ff.short_sel && l_ff.st != SBB_ST_IDLE |-> l_ff.step != SBB_SQ_INDEX)
        else $error("Index byte sent in short protocol.");

    AST_QTR_RATE: assert property (@(posedge link_clk) disable iff (!link_rst_n) // RULE12
        l_ff.st != SBB_ST_IDLE && !fast && !$past(fast) && $changed(l_ff.phase)
        |-> $past(l_ff.qcnt) == SBB_QTR_NORMAL - 8'h01)
        else $error("Serial clock phase length wrong.");

    AST_STOP_FREE: assert property (@(posedge link_clk) disable iff (!link_rst_n) // RULE13
        l_ff.st == SBB_ST_STOP && l_ff.phase == 2'h3 |-> !l_ff.scl_low && !l_ff.sda_low ##1 l_ff.st != SBB_ST_BIT)
        else $error("Bus not released at stop.");

    COV_WRITE_DONE: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(h_ff.busy) && !h_ff.target[SBB_TGT_DIR_BIT] && !h_ff.err);
    COV_READ_DONE: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(h_ff.busy) && h_ff.target[SBB_TGT_DIR_BIT] && !h_ff.err);
    COV_NACK: cover property (@(posedge clk) disable iff (!rst_n) $rose(h_ff.err));
    COV_SHORT_READ: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        l_ff.short_sel && l_ff.step == SBB_SQ_DATA_R);
endmodule : sbb_byte_access
`default_nettype wire

// ==== sbb_pkg.sv ====
package sbb_pkg;

    // Register offsets on the configuration port.
    localparam logic [7:0] SBB_OFS_DATA   = 8'hb0;
    localparam logic [7:0] SBB_OFS_INDEX  = 8'hb1;
    localparam logic [7:0] SBB_OFS_TARGET = 8'hb2;
    localparam logic [7:0] SBB_OFS_CTRL   = 8'hb3;

    // Reset values.
    localparam logic [7:0] SBB_RST_DATA   = 8'h00;
    localparam logic [7:0] SBB_RST_INDEX  = 8'h00;
    localparam logic [7:0] SBB_RST_TARGET = 8'h00;
    localparam logic [7:0] SBB_RST_CTRL   = 8'h00;

    // Field positions.
    localparam int SBB_TGT_DIR_BIT    = 0;
    localparam int SBB_CTRL_SHORT_BIT = 7;
    localparam int SBB_CTRL_BUSY_BIT  = 5;
    localparam int SBB_CTRL_TEST_BIT  = 2;
    localparam int SBB_CTRL_ERR_BIT   = 1;

    // Serial clock timing, each phase of a bit lasts a quarter period of the serial clock.
    localparam int SBB_SCL_NORMAL_NS = 10000;
    localparam int SBB_SCL_TEST_NS   = 1000;
    localparam int SBB_LINK_CLK_NS   = 15;
    localparam logic [7:0] SBB_QTR_NORMAL = 8'(SBB_SCL_NORMAL_NS / (4 * SBB_LINK_CLK_NS));
    localparam logic [7:0] SBB_QTR_TEST   = 8'(SBB_SCL_TEST_NS / (4 * SBB_LINK_CLK_NS));

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbb_cfg_req_s;

    typedef enum logic [1:0] {SBB_ST_IDLE, SBB_ST_START, SBB_ST_BIT, SBB_ST_STOP} sbb_state_e;

    typedef enum logic [2:0] {
        SBB_SQ_ADDR_W, SBB_SQ_INDEX, SBB_SQ_DATA_W, SBB_SQ_ADDR_R, SBB_SQ_DATA_R
    } sbb_step_e;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] index;
        logic [7:0] target;
        logic       short_sel;
        logic       fast;
        logic       err;
        logic       busy;
        logic       launch_tgl;
        logic       done_seen;
        logic [7:0] rdata;
    } sbb_host_s;

    typedef struct packed {
        sbb_state_e st;
        sbb_step_e  step;
        logic [1:0] phase;
        logic [7:0] qcnt;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] rx;
        logic       err;
        logic       scl_low;
        logic       sda_low;
        logic       done_tgl;
        logic       launch_seen;
        logic       short_sel;
        logic       rd;
    } sbb_link_s;

endpackage : sbb_pkg

// ==== sbb_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sbb_sync_s;

    sbb_sync_s sync_ff;
    sbb_sync_s nxt_sync;

    always_comb begin
        nxt_sync.s1 = d;
        nxt_sync.s2 = sync_ff.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign q = sync_ff.s2;
endmodule : sbb_sync
`default_nettype wire

// ==== sbb_target_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbb_target_model #(
    parameter logic [6:0] TGT_ADDR = 7'h2a // Arbitrary bus address for the bench.
) (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic sda_oe_n
);
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       act;
    logic       sel;
    logic       rd;
    int         bn;
    int         bc;

    initial begin
        sda_oe_n = 1'b1;
        act = 1'b0;
        ptr = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // A start, repeated or not, restarts the byte count from the address byte.
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        sel = 1'b0;
        rd = 1'b0;
        bn = -1;
        bc = 0;
        sda_oe_n = 1'b1;
    end

    always @(posedge sda) if (scl === 1'b1) begin
        act = 1'b0;
        sda_oe_n = 1'b1;
    end

    // A released line in the acknowledge slot of a read byte ends our part of the frame.
    always @(posedge scl) if (act) begin
        if (bn < 8) sh = {sh[6:0], sda};
        else if (rd && bc > 0 && sda === 1'b1) act = 1'b0;
    end

    always @(negedge scl) if (act) begin
        bn = bn + 1;
        if (bn == 8) begin
            if (bc == 0) begin
                sel = (sh[7:1] == TGT_ADDR);
                rd = sh[0];
            end else if (sel && !rd && bc == 1) begin
                ptr = sh;
            end else if (sel && !rd) begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            sda_oe_n = !(sel && (bc == 0 || !rd));
        end else begin
            if (bn == 9) begin
                bn = 0;
                bc = bc + 1;
                if (rd && sel) begin
                    tx = mem[ptr];
                    ptr = ptr + 8'h01;
                end
            end
            sda_oe_n = (rd && sel && bc > 0) ? tx[7-bn] : 1'b1;
        end
    end
endmodule : sbb_target_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sbb_pkg::*;
;
    localparam logic [6:0] TGT = 7'h2a; // Arbitrary target address.
    localparam realtime PER = 4 * SBB_QTR_TEST * SBB_LINK_CLK_NS;
    localparam realtime PER_N = 4 * SBB_QTR_NORMAL * SBB_LINK_CLK_NS;

    logic         clk;
    logic         rst_n;
    logic         link_clk;
    sbb_cfg_req_s cfg_req;
    logic [7:0]   cfg_rdata;
    logic         scl_o;
    logic         scl_oe_n;
    logic         sda_o;
    logic         sda_oe_n;
    logic         m_sda_oe_n;
    wire logic    scl_w;
    wire logic    sda_w;
    int           err_count = 0;
    int           compares = 0;
    int           cyc = 0;
    realtime      t_rise = 0;
    realtime      t_prev = 0;

    // Open-drain lines with pull-ups: low while any party enables its driver.
    assign scl_w = scl_oe_n ? 1'b1 : scl_o;
    assign sda_w = !sda_oe_n ? sda_o : (m_sda_oe_n ? 1'b1 : 1'b0);

    sbb_byte_access sbb_byte_access_inst (
        .clk       (clk),
        .rst_n     (rst_n),
        .link_clk  (link_clk),
        .cfg_req   (cfg_req),
        .cfg_rdata (cfg_rdata),
        .scl_i     (scl_w),
        .scl_o     (scl_o),
        .scl_oe_n  (scl_oe_n),
        .sda_i     (sda_w),
        .sda_o     (sda_o),
        .sda_oe_n  (sda_oe_n)
    );

    sbb_target_model #(.TGT_ADDR(TGT)) sbb_target_model_inst (
        .scl      (scl_w),
        .sda      (sda_w),
        .sda_oe_n (m_sda_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end

    always @(posedge scl_w) begin
        t_prev = t_rise;
        t_rise = $realtime;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            $display("wrong value at %0t: run did not finish in time", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        cfg_req <= '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        cfg_req <= '0;
        @(posedge clk);
        #1;
        d = cfg_rdata;
    endtask : reg_rd

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        reg_rd(a, d);
        chk(d, exp, msg);
    endtask : expect_reg

    // Polling is bounded; a stuck busy flag is caught by the cycle ceiling.
    task automatic wait_idle;
        logic [7:0] s;
        int n;
        n = 0;
        do begin
            reg_rd(SBB_OFS_CTRL, s);
            n++;
        end while (s[SBB_CTRL_BUSY_BIT] !== 1'b0 && n < 6000);
    endtask : wait_idle

    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        cfg_req = '0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) expect_reg(SBB_OFS_DATA + 8'(i), 8'h00, "reset value");
        reg_wr(8'hb4, 8'hff);
        expect_reg(8'hb4, 8'h00, "unmapped offset");
        reg_wr(SBB_OFS_CTRL, 8'h04);
        expect_reg(SBB_OFS_CTRL, 8'h04, "test clock bit");
        $display("test registers done");

        reg_wr(SBB_OFS_DATA, 8'h5a);
        reg_wr(SBB_OFS_INDEX, 8'h21);
        expect_reg(SBB_OFS_DATA, 8'h5a, "data readback");
        expect_reg(SBB_OFS_INDEX, 8'h21, "index readback");
        reg_wr(SBB_OFS_TARGET, {TGT, 1'b0});
        expect_reg(SBB_OFS_CTRL, 8'h24, "busy after launch");
        reg_wr(SBB_OFS_DATA, 8'hff);
        expect_reg(SBB_OFS_DATA, 8'h5a, "data write while busy");
        wait_idle();
        chk(sbb_target_model_inst.mem[8'h21], 8'h5a, "byte written at index");
        expect_reg(SBB_OFS_TARGET, {TGT, 1'b0}, "target readback");
        chk(8'(t_rise - t_prev >= PER && t_rise - t_prev <= PER + 120), 8'h01, "clock period");
        $display("test byte write done");

        reg_wr(SBB_OFS_DATA, 8'h00);
        reg_wr(SBB_OFS_TARGET, {TGT, 1'b1});
        wait_idle();
        expect_reg(SBB_OFS_DATA, 8'h5a, "read byte");
        expect_reg(SBB_OFS_TARGET, {TGT, 1'b1}, "direction readback");
        $display("test byte read done");

        reg_wr(SBB_OFS_TARGET, {TGT ^ 7'h01, 1'b1});
        wait_idle();
        expect_reg(SBB_OFS_CTRL, 8'h06, "error flag set");
        expect_reg(SBB_OFS_DATA, 8'h5a, "data kept on error");
        reg_wr(SBB_OFS_CTRL, 8'h06);
        expect_reg(SBB_OFS_CTRL, 8'h04, "error flag cleared");
        $display("test missing acknowledge done");

        reg_wr(SBB_OFS_INDEX, 8'h77);
        reg_wr(SBB_OFS_CTRL, 8'h84);
        reg_wr(SBB_OFS_DATA, 8'h21);
        reg_wr(SBB_OFS_TARGET, {TGT, 1'b0});
        wait_idle();
        reg_wr(SBB_OFS_DATA, 8'h00);
        reg_wr(SBB_OFS_TARGET, {TGT, 1'b1});
        wait_idle();
        expect_reg(SBB_OFS_DATA, 8'h5a, "receive byte");
        chk(sbb_target_model_inst.mem[8'h77], 8'h00, "index left out");
        $display("test short protocol done");

        // A frame cut short by a missing acknowledge keeps the normal-rate run short.
        reg_wr(SBB_OFS_CTRL, 8'h00);
        reg_wr(SBB_OFS_TARGET, {TGT ^ 7'h01, 1'b0});
        wait_idle();
        chk(8'(t_rise - t_prev >= PER_N && t_rise - t_prev <= PER_N + 120), 8'h01, "normal clock period");
        expect_reg(SBB_OFS_CTRL, 8'h02, "error flag at normal rate");
        $display("test normal clock rate done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
